// >>> rtl/bfs_top.sv
// Purpose: Startup sequencing and protection for a synchronous buck controller.
// Assumes: Comparator and pin inputs are synchronous to pclk; APB3 slave.
// Notes: Gate drive outputs are registered; gates follow pwm_high when allowed.
`timescale 1ns/1ps
module bfs_top
  import bfs_pkg::*;
#(
  parameter int STARTUP_CYC_P = bfs_pkg::STARTUP_CYC,
  parameter int HICCUP_CYC_P = bfs_pkg::HICCUP_CYC,
  parameter int DEGLITCH_CYC_P = bfs_pkg::DEGLITCH_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bfs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic input_supply_ok,
  input wire logic vdd_ok,
  input wire logic en_above_thr,
  input wire logic en_above_deep,
  input wire logic ss_cap_fitted,
  input wire logic ss_above_fb,
  input wire logic ss_above_done,
  input wire logic prebias_high,
  input wire logic fb_above_uv,
  input wire logic ov_fault,
  input wire logic oc_event,
  input wire logic switch_node_above_limit,
  input wire logic zero_current,
  input wire logic overtemp,
  input wire logic pwm_high,
  input wire logic sync_present,
  input wire logic sync_clk_in,
  input wire logic osc_clk_in,
  output logic hs_gate,
  output logic ls_gate,
  output logic ss_discharge,
  output logic bias_on,
  output logic power_good_output
);
  import bfs_pkg::*;

  localparam int TMAX = (STARTUP_CYC_P > HICCUP_CYC_P) ? STARTUP_CYC_P : HICCUP_CYC_P;
  localparam int TMR_W = $clog2(TMAX + 1);

  if (STARTUP_CYC_P < 2 || HICCUP_CYC_P < 2) begin : g_bad_time
    $error("bfs_top: startup and hiccup counts must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Qualified inputs and switching-cycle edge
  logic ok_supply, en_on, cycle_src, cycle_start, oc_pulse;
  logic src_reg, oc_in_reg;
  logic run_en_reg, run_en_next;

  assign ok_supply = input_supply_ok & vdd_ok;
  assign en_on = en_above_thr & run_en_reg;
  assign cycle_src = sync_present ? sync_clk_in : osc_clk_in;
  assign cycle_start = cycle_src & ~src_reg;
  assign oc_pulse = oc_event & ~oc_in_reg;

  // Edge history; oc_event is counted once per assertion, not per clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg <= 1'b0;
      oc_in_reg <= 1'b0;
    end else begin
      src_reg <= cycle_src;
      oc_in_reg <= oc_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state and its shared timer
  bfs_state_t state_reg, state_next;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic gate_ok_reg, gate_ok_next;
  logic hiccup_trig;
  logic [OC_W-1:0] oc_cnt_reg, oc_cnt_next;

  assign hiccup_trig = (oc_cnt_next == OC_W'(OC_LIMIT));

  // Faults override everything; lockout is the common restart point
  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    gate_ok_next = gate_ok_reg;
    if (!en_above_deep) begin
      state_next = BFS_OFF;
      tmr_next = '0;
      gate_ok_next = 1'b0;
    end else if (!ok_supply || overtemp || !en_on) begin
      state_next = BFS_LOCK;
      tmr_next = '0;
      gate_ok_next = 1'b0;
    end else begin
      unique case (state_reg)
        BFS_OFF: begin
          state_next = BFS_LOCK;
        end
        BFS_LOCK: begin
          state_next = BFS_SOFT;
          tmr_next = '0;
        end
        BFS_SOFT: begin
          if (tmr_reg != TMR_W'(STARTUP_CYC_P - 1)) begin
            tmr_next = tmr_reg + 1'b1;
          end
          if (ss_above_fb && !prebias_high) begin
            gate_ok_next = 1'b1;
          end
          if (hiccup_trig) begin
            state_next = BFS_DRAIN;
          end else if (tmr_reg == TMR_W'(STARTUP_CYC_P - 1) && gate_ok_reg &&
                       (!ss_cap_fitted || ss_above_done)) begin
            state_next = BFS_RUN;
          end
        end
        BFS_RUN: begin
          if (hiccup_trig) begin
            state_next = BFS_DRAIN;
          end
        end
        BFS_DRAIN: begin
          gate_ok_next = 1'b0;
          if (zero_current) begin
            state_next = BFS_WAIT;
            tmr_next = '0;
          end
        end
        BFS_WAIT: begin
          tmr_next = tmr_reg + 1'b1;
          if (tmr_reg == TMR_W'(HICCUP_CYC_P - 1)) begin
            state_next = BFS_LOCK;
          end
        end
      endcase
    end
  end

  // Start in deep shutdown; bias comes up only once enable is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= BFS_OFF;
      tmr_reg <= '0;
      gate_ok_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      gate_ok_reg <= gate_ok_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Over-current counting and cycle-by-cycle blanking
  logic switching, switching_next;
  logic [QUIET_W-1:0] quiet_reg, quiet_next;
  logic oc_block_reg, oc_block_next;

  assign switching = state_reg == BFS_RUN || (state_reg == BFS_SOFT && gate_ok_reg);
  assign switching_next = state_next == BFS_RUN || (state_next == BFS_SOFT && gate_ok_next);

  // An event on a cycle edge still blanks that new cycle: set wins
  always_comb begin
    oc_cnt_next = oc_cnt_reg;
    quiet_next = quiet_reg;
    oc_block_next = oc_block_reg;
    if (!switching) begin
      oc_cnt_next = '0;
      quiet_next = '0;
      // Track the level so an event on the very edge that switching starts still blanks
      oc_block_next = oc_event;
    end else begin
      if (cycle_start) begin
        oc_block_next = 1'b0;
      end
      if (oc_event) begin
        oc_block_next = 1'b1;
      end
      if (oc_pulse) begin
        quiet_next = '0;
        if (oc_cnt_reg != OC_W'(OC_LIMIT)) begin
          oc_cnt_next = oc_cnt_reg + 1'b1;
        end
      end else if (cycle_start) begin
        if (quiet_reg == QUIET_W'(QUIET_CYCLES - 1)) begin
          quiet_next = '0;
          oc_cnt_next = '0;
        end else begin
          quiet_next = quiet_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_cnt_reg <= '0;
      quiet_reg <= '0;
      oc_block_reg <= 1'b0;
    end else begin
      oc_cnt_reg <= oc_cnt_next;
      quiet_reg <= quiet_next;
      oc_block_reg <= oc_block_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate drive, soft-start discharge, bias and power-good
  bfs_filt_if pg_if ();
  logic neg_reg, neg_next;
  logic hs_next, ls_next, ss_dis_next, bias_next, pg_next;

  assign pg_if.raw = state_reg == BFS_RUN && fb_above_uv && ss_above_done && !ov_fault &&
                     !oc_block_reg && !prebias_high && ok_supply && !overtemp;

  bfs_deglitch #(
    .FILT_CYC(DEGLITCH_CYC_P)
  ) u_pg_filt (
    .pclk(pclk),
    .presetn(presetn),
    .fif(pg_if.filt)
  );

  // Gates derive from next state so a fault removes drive on the same edge
  always_comb begin
    neg_next = ov_fault && !pwm_high && (neg_reg || switch_node_above_limit);
    hs_next = switching_next && pwm_high && !oc_block_next;
    ls_next = (switching_next && !pwm_high && !neg_next) || state_next == BFS_DRAIN;
    ss_dis_next = state_next inside {BFS_OFF, BFS_LOCK, BFS_DRAIN, BFS_WAIT};
    bias_next = state_next != BFS_OFF;
    pg_next = pg_if.filtered && !overtemp;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      neg_reg <= 1'b0;
      hs_gate <= 1'b0;
      ls_gate <= 1'b0;
      ss_discharge <= 1'b1;
      bias_on <= 1'b0;
      power_good_output <= 1'b0;
    end else begin
      neg_reg <= neg_next;
      hs_gate <= hs_next;
      ls_gate <= ls_next;
      ss_discharge <= ss_dis_next;
      bias_on <= bias_next;
      power_good_output <= pg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, data and error registered with pready
  logic acc, wr;
  logic [EVT_W-1:0] evt_reg, evt_next, evt_set;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;

  assign acc = psel && penable && !pready;
  assign wr = psel && penable && pready && pwrite;
  assign evt_set = {oc_pulse, ok_supply ? 1'b0 : bias_on, overtemp,
                    state_next == BFS_DRAIN && state_reg != BFS_DRAIN};

  // Sticky events: a new event beats a clear in the same cycle
  always_comb begin
    pready_next = acc;
    pslverr_next = 1'b0;
    prdata_next = 32'h0000_0000;
    run_en_next = run_en_reg;
    evt_next = evt_reg | evt_set;
    if (acc) begin
      unique case (paddr)
        CTRL_OFS: prdata_next = {31'h0000_0000, run_en_reg};
        STATUS_OFS: prdata_next = {20'h0_0000, ss_discharge, ls_gate, hs_gate, power_good_output,
                                   1'b0, oc_cnt_reg, 1'b0, state_reg};
        EVENTS_OFS: prdata_next = {28'h000_0000, evt_reg};
        default: pslverr_next = 1'b1;
      endcase
    end
    if (wr && paddr == CTRL_OFS) begin
      run_en_next = pwdata[CTRL_RUN_BIT];
    end
    if (wr && paddr == EVENTS_OFS) begin
      evt_next = (evt_reg & ~pwdata[EVT_W-1:0]) | evt_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      run_en_reg <= CTRL_RUN_RST;
      evt_reg <= EVT_RST;
    end else begin
      pready <= pready_next;
      pslverr <= pslverr_next;
      prdata <= prdata_next;
      run_en_reg <= run_en_next;
      evt_reg <= evt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  lockout_gates_a: assert property (!ok_supply |=> !hs_gate && !ls_gate)
    else $error("gate driven during supply lockout");
  enable_start_a: assert property (state_reg == BFS_LOCK && en_on && ok_supply && !overtemp &&
    en_above_deep |=> state_reg == BFS_SOFT)
    else $error("soft-start did not begin after enable");
  deep_bias_a: assert property (!en_above_deep |=> !bias_on && state_reg == BFS_OFF)
    else $error("bias on in deep shutdown");
  startup_min_a: assert property (state_reg == BFS_SOFT && state_next == BFS_RUN |->
    tmr_reg == TMR_W'(STARTUP_CYC_P - 1))
    else $error("startup completed before fixed time");
  prebias_hold_a: assert property (state_reg == BFS_SOFT && !gate_ok_reg && (!ss_above_fb || prebias_high) &&
    !hiccup_trig |=> !hs_gate && !ls_gate)
    else $error("switching before ramp passed feedback");
  oc_blank_a: assert property (oc_event |=> !hs_gate)
    else $error("high side on after over-current");
  quiet_clear_a: assert property (switching && cycle_start && !oc_pulse &&
    quiet_reg == QUIET_W'(QUIET_CYCLES - 1) |=> oc_cnt_reg == '0)
    else $error("count not cleared after quiet cycles");
  hiccup_enter_a: assert property (switching && oc_pulse && oc_cnt_reg == OC_W'(OC_LIMIT - 1) &&
    ok_supply && en_on && en_above_deep && !overtemp |=> state_reg == BFS_DRAIN ##1 ss_discharge)
    else $error("hiccup not entered on fifth event");
  drain_gates_a: assert property (state_reg == BFS_DRAIN |-> !hs_gate)
    else $error("high side on while draining");
  neg_limit_a: assert property (ov_fault && switch_node_above_limit && !pwm_high |=> !ls_gate ||
    state_reg == BFS_DRAIN)
    else $error("low side on above negative limit");
  otemp_off_a: assert property (overtemp |=> !hs_gate && !ls_gate && !power_good_output)
    else $error("over-temperature did not shut gates and power-good");

  run_cover_c: cover property (state_reg == BFS_SOFT ##1 state_reg == BFS_RUN);
  hiccup_cover_c: cover property (state_reg == BFS_WAIT ##1 state_reg == BFS_LOCK);
  pg_cover_c: cover property ($rose(power_good_output));

endmodule

// >>> rtl/bfs_pkg.sv
// Purpose: Shared constants and types for the buck fault sequencer.
// Assumes: pclk at 125 MHz; all times expressed as whole microseconds.
// Notes: Cycle counts are derived from the times and the clock rate.
package bfs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and times
  localparam int CLK_MHZ = 125;
  localparam int T_STARTUP_US = 1280;    // Fixed startup ramp, 1.28 ms
  localparam int T_HICCUP_US = 1280;     // Hiccup off time, 1.28 ms
  localparam int T_DEGLITCH_US = 20;     // Power-good filter, 20 us
  localparam int STARTUP_CYC = T_STARTUP_US * CLK_MHZ;
  localparam int HICCUP_CYC = T_HICCUP_US * CLK_MHZ;
  localparam int DEGLITCH_CYC = T_DEGLITCH_US * CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Over-current counting
  localparam int OC_LIMIT = 5;           // Events that send us into hiccup
  localparam int QUIET_CYCLES = 32;      // Clean cycles that clear the count
  localparam int OC_W = 3;
  localparam int QUIET_W = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, APB byte addresses
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] EVENTS_OFS = 12'h008;
  localparam int CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam int EVT_W = 4;
  localparam int EVT_HICCUP_BIT = 0;
  localparam int EVT_OTEMP_BIT = 1;
  localparam int EVT_LOCK_BIT = 2;
  localparam int EVT_OC_BIT = 3;
  localparam logic [EVT_W-1:0] EVT_RST = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [2:0] {
    BFS_OFF,
    BFS_LOCK,
    BFS_SOFT,
    BFS_RUN,
    BFS_DRAIN,
    BFS_WAIT
  } bfs_state_t;

endpackage

// >>> rtl/bfs_filt_if.sv
// Purpose: Carries the raw and filtered power-good condition.
// Assumes: Both ends run on pclk.
// Notes: No clocking block; ends supply their own clock.
`timescale 1ns/1ps
interface bfs_filt_if;
  logic raw;
  logic filtered;
  modport filt (input raw, output filtered);
  modport user (output raw, input filtered);
endinterface

// >>> rtl/bfs_deglitch.sv
// Purpose: Persistence filter for the power-good condition.
// Assumes: raw is synchronous to pclk.
// Notes: A change passes only after it has held for FILT_CYC cycles.
`timescale 1ns/1ps
module bfs_deglitch
  import bfs_pkg::*;
#(
  parameter int FILT_CYC = bfs_pkg::DEGLITCH_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  bfs_filt_if.filt fif
);
  import bfs_pkg::*;

  localparam int CW = $clog2(FILT_CYC + 1);

  if (FILT_CYC < 2) begin : g_bad_filt
    $error("bfs_deglitch: FILT_CYC must be at least 2");
  end

  logic [CW-1:0] cnt_reg, cnt_next;
  logic out_reg, out_next;

  ////////////////////////////////////////////////////////////////////////////
  // Restart the count whenever raw agrees with the output again
  always_comb begin
    cnt_next = '0;
    out_next = out_reg;
    if (fif.raw != out_reg) begin
      if (cnt_reg == CW'(FILT_CYC - 1)) begin
        out_next = fif.raw;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  // Output low from reset so power-good never glitches high at power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign fif.filtered = out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  filter_pass_a: assert property ((fif.raw != out_reg) && (cnt_reg == CW'(FILT_CYC - 1))
    |=> out_reg == $past(fif.raw))
    else $error("filtered power-good did not follow persistent change");
  filter_hold_a: assert property ((cnt_reg < CW'(FILT_CYC - 1)) |=> $stable(out_reg))
    else $error("filtered power-good changed before the filter time");

endmodule

// >>> verif/bfs_power_stage.sv
// Purpose: Behavioural switch pair and inductor at the far side of the gate drivers.
// Assumes: Gate commands are active high and registered on pclk.
// Notes: Current moves in unit steps; slow stretches each step to four cycles.
`timescale 1ns/1ps
module bfs_power_stage (
  input wire logic pclk,
  input wire logic hs_gate,
  input wire logic ls_gate,
  input wire logic slow,
  output logic zero_current,
  output logic switch_node_above_limit
);
  int cur = 0;
  int div = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Inductor current; clamped so long runs stay bounded, freewheels down to zero when both are off and it is positive
  always @(posedge pclk) begin
    div <= (div + 1) % 4;
    if (!slow || div == 0) begin
      if (hs_gate && cur < 40)
        cur <= cur + 1;
      else if (ls_gate && cur > -8)
        cur <= cur - 1;
      else if (!hs_gate && !ls_gate && cur > 0)
        cur <= cur - 1;
    end
  end
  // Node sits above ground only while the low side carries reverse current
  assign zero_current = (cur == 0);
  assign switch_node_above_limit = ls_gate && (cur < 0);
endmodule

// >>> verif/bfs_top_tb.sv
// Purpose: Self-checking bench for the buck fault sequencer.
// Assumes: Short timer parameters; all inputs change on pclk edges.
// Notes: Cycle clocks are derived from pclk so they stay synchronous to it.
`timescale 1ns/1ps
module bfs_top_tb;
  import bfs_pkg::*;
  localparam int ST_P = 20;
  localparam int HI_P = 30;
  localparam int DG_P = 8;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, hs_gate, ls_gate, ss_discharge, bias_on, power_good_output;
  logic input_supply_ok = 0, vdd_ok = 0, en_above_thr = 0, en_above_deep = 0, ss_cap_fitted = 0;
  logic ss_above_fb = 0, ss_above_done = 0, prebias_high = 0, fb_above_uv = 0, ov_fault = 0;
  logic oc_event = 0, overtemp = 0, pwm_high = 1, sync_present = 1, sync_clk_in = 0, osc_clk_in = 0;
  logic zero_current, switch_node_above_limit, slow = 0, err;
  int bad_count = 0, checks = 0, cyc = 0, t0;
  logic [6:0] row_in [8];
  logic [5:0] row_exp [8];
  wire cyc_clk = sync_present ? sync_clk_in : osc_clk_in;

  bfs_top #(.STARTUP_CYC_P(ST_P), .HICCUP_CYC_P(HI_P), .DEGLITCH_CYC_P(DG_P)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_supply_ok(input_supply_ok), .vdd_ok(vdd_ok), .en_above_thr(en_above_thr),
    .en_above_deep(en_above_deep), .ss_cap_fitted(ss_cap_fitted), .ss_above_fb(ss_above_fb),
    .ss_above_done(ss_above_done), .prebias_high(prebias_high), .fb_above_uv(fb_above_uv),
    .ov_fault(ov_fault), .oc_event(oc_event), .switch_node_above_limit(switch_node_above_limit),
    .zero_current(zero_current), .overtemp(overtemp), .pwm_high(pwm_high),
    .sync_present(sync_present), .sync_clk_in(sync_clk_in), .osc_clk_in(osc_clk_in),
    .hs_gate(hs_gate), .ls_gate(ls_gate), .ss_discharge(ss_discharge), .bias_on(bias_on),
    .power_good_output(power_good_output));
  bfs_power_stage stage_u (.pclk(pclk), .hs_gate(hs_gate), .ls_gate(ls_gate), .slow(slow),
    .zero_current(zero_current), .switch_node_above_limit(switch_node_above_limit));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, cycle counter and two pclk-derived switching-cycle clocks of different periods
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sync_clk_in <= (cyc % 10) < 5;
    osc_clk_in <= (cyc % 12) < 6;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    if (k >= 20)
      bad_count++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Bounded wait: 0 power good, 1 low side, 2 soft-start discharge
  task automatic wait_sig(input int s, input logic lvl);
    int k;
    k = 0;
    while (((s == 0) ? power_good_output : (s == 1) ? ls_gate : ss_discharge) !== lvl && k < 600) begin
      @(posedge pclk);
      k++;
    end
    // A wait that runs out is a failure, not a silent pass
    if (k >= 600)
      bad_count++;
  endtask
  // Over-current pulse early in a switching cycle; high side checked off three clocks after the pulse
  task automatic oc_hit(input logic rel);
    @(posedge cyc_clk);
    repeat (2) @(posedge pclk);
    oc_event <= 1'b1;
    @(posedge pclk);
    oc_event <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("hs_blank", hs_gate, 1'b1 ^ 1'b1);
    if (rel) begin
      @(posedge cyc_clk);
      repeat (5) @(posedge pclk);
      chk("hs_resume", hs_gate, 1'b1);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: whole run needs well under two thousand cycles
  initial begin
    repeat (8000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    // In {deep, thr, vin, vdd, otemp, fb, prebias}; out {bias, ssd, hs, state}
    row_in = '{7'h3A, 7'h5A, 7'h6A, 7'h72, 7'h7E, 7'h78, 7'h7B, 7'h7A};
    row_exp = '{6'h10, 6'h31, 6'h31, 6'h31, 6'h31, 6'h22, 6'h22, 6'h2A};
    repeat (3) @(posedge pclk);
    chk("reset_out", {hs_gate, ls_gate, ss_discharge, bias_on, power_good_output}, 5'h04);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    chk("ctrl_reset", rd, 32'h0000_0001);
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_data", rd, 32'h0000_0000);
    // Qualification table, each row from the off state
    for (int i = 0; i < 8; i++) begin
      en_above_deep <= 1'b0;
      repeat (2) @(posedge pclk);
      {en_above_deep, en_above_thr, input_supply_ok, vdd_ok, overtemp, ss_above_fb, prebias_high} <= row_in[i];
      repeat (5) @(posedge pclk);
      apb(1'b0, STATUS_OFS, 32'h0000_0000);
      chk("row", {bias_on, ss_discharge, hs_gate, rd[2:0]}, row_exp[i]);
    end
    // Startup with capacitor fitted holds until the node is done and the fixed time elapsed
    en_above_deep <= 1'b0;
    repeat (2) @(posedge pclk);
    {ss_cap_fitted, fb_above_uv, en_above_deep} <= 3'h7;
    t0 = cyc;
    repeat (60) @(posedge pclk);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("soft_hold", {power_good_output, rd[2:0]}, 4'h2);
    ss_above_done <= 1'b1;
    wait_sig(0, 1'b1);
    chk("pg_up", power_good_output, 1'b1);
    chk("pg_time", (cyc - t0) >= ST_P + DG_P, 1'b1);
    // Over-voltage: power good filtered then low; reverse current cut only while armed
    pwm_high <= 1'b0;
    ov_fault <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("pg_filter", power_good_output, 1'b1);
    repeat (12) @(posedge pclk);
    chk("pg_ov", power_good_output, 1'b0);
    repeat (60) @(posedge pclk);
    chk("neg_limit", ls_gate, 1'b0);
    ov_fault <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("neg_unarmed", ls_gate, 1'b1);
    pwm_high <= 1'b1;
    wait_sig(0, 1'b1);
    // Over-current counting on both cycle sources, then quiet clear
    oc_hit(1'b1);
    sync_present <= 1'b0;
    @(posedge pclk);
    oc_hit(1'b1);
    sync_present <= 1'b1;
    @(posedge pclk);
    oc_hit(1'b0);
    oc_hit(1'b0);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("oc_count", rd[6:4], 3'h4);
    repeat (34) @(posedge cyc_clk);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("oc_quiet", rd[6:4], 3'h0);
    // Five quick events: drain with a slow inductor, wait, then restart
    slow <= 1'b1;
    repeat (5) oc_hit(1'b0);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("hiccup", {rd[2:0], hs_gate, ls_gate, ss_discharge}, 6'h23);
    wait_sig(1, 1'b0);
    t0 = cyc;
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("drained", {rd[2:0], zero_current}, 4'hB);
    wait_sig(2, 1'b0);
    chk("hiccup_wait", (cyc - t0) >= HI_P, 1'b1);
    slow <= 1'b0;
    apb(1'b0, EVENTS_OFS, 32'h0000_0000);
    chk("evt_set", rd[3:0] & 4'h9, 4'h9);
    apb(1'b1, EVENTS_OFS, 32'h0000_000F);
    apb(1'b0, EVENTS_OFS, 32'h0000_0000);
    chk("evt_clear", rd[3:0], 4'h0);
    wait_sig(0, 1'b1);
    chk("restart_pg", power_good_output, 1'b1);
    // Thermal fault forces both gates and power good off
    overtemp <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("otemp", {hs_gate, ls_gate, power_good_output}, 3'h0);
    overtemp <= 1'b0;
    // Software run bit gates the enable qualification
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk("run_off", rd[2:0], 3'h1);
    give_verdict();
  end
endmodule
